/* File: block_check_calculator.sv */
// block check calculator: follows decoded characters, brackets blocks or frames,
// accumulates lrc, crc or fcs and compares against the received check characters
// assumes characters and frame markers arrive synchronous to mclk, one per cycle at most
//
// How it works
// R01: in character mode a begin code opens a block and accumulation starts with the next char.
// R02: in character mode an end code is accumulated and then accumulation stops.
// R03: after an end code in an open block the following chars are taken as the check value.
// R04: the intermediate block code closes accumulation exactly like an end code.
// R05: in flag mode accumulation starts with the first char after flag synchronisation.
// R06: in flag mode the chars just before the closing flag are the fcs, the rest is accumulated.
// R07: transparent handling uses a programmable escape char and exists only in character mode.
// R08: in transparent blocks escape plus begin opens, escape plus end closes, a lone end is data.
// R09: escape chars are left out of the accumulation in transparent blocks.
// R10: of two escapes back to back only the first is dropped, the second is data.
// R11: a sync char right after an escape is dropped as well.
// R12: a block opened by a begin code without escape runs as if transparency were off.
// R13: longitudinal parity can be odd or even.
// R14: crc types x6+x5+1, x12+x11+x3+x2+x+1, x16+x15+x2+1 and x16+x12+x5+1 are offered.
// R15: flag mode offers 16 and 32 bit fcs with the register preset to all ones.
// R16: each finished check gives an error pulse on mismatch and a pass pulse otherwise.
// R17: the accumulator is preset at each block or frame start and chars outside are ignored.
`timescale 1ns/1ps

module block_check_calculator
  import bcc_pkg::*;
(
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // decoded characters from the line receiver
  input  wire bcc_pkg::rx_t  rx,
  // register port
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // check results
  output logic               check_pass,
  output logic               check_error,
  output logic               irq
);

  import bcc_pkg::*;

  state_t s_q;
  state_t s_d;

  logic [2:0]  need;
  logic        is_begin;
  logic        is_end;
  logic        is_esc;
  logic        is_sync;
  logic        tr_on;
  logic [31:0] win_nx;

  assign need     = alg_len(s_q.ctrl.alg);
  assign is_begin = (rx.data == s_q.codes.begin0) || (rx.data == s_q.codes.begin1);
  assign is_end   = (rx.data == s_q.codes.end0) || (rx.data == s_q.codes.end1)
                    || (rx.data == s_q.codes.itb);
  assign is_esc   = rx.data == s_q.codes.escape_char_value;
  assign is_sync  = rx.data == s_q.codes.sync;
  assign tr_on    = s_q.ctrl.escape_transparency_setting && !s_q.ctrl.mode_flag;
  assign win_nx   = {rx.data, s_q.win[31:8]};

  always_comb
  begin
    logic [31:0] expv;
    logic [31:0] gotv;
    logic        ev_pass;
    logic        ev_err;
    logic [1:0]  clr;
    expv    = alg_expect(s_q.ctrl.alg, s_q.ctrl.longitudinal_parity_odd, s_q.acc);
    gotv    = win_take(win_nx, need);
    ev_pass = 1'b0;
    ev_err  = 1'b0;
    clr     = 2'h0;
    s_d       = s_q;
    s_d.pass  = 1'b0;
    s_d.err   = 1'b0;
    s_d.rdata = 32'h0000_0000;

    case (s_q.st)
      ST_IDLE:
      begin
        if (s_q.ctrl.mode_flag)
          s_d.esc_pend = 1'b0;
        else if (rx.valid)
        begin
          if (is_begin)
          begin
            s_d.st       = ST_OPEN;                      // [R01]
            s_d.acc      = alg_init(s_q.ctrl.alg);       // [R17]
            s_d.tr       = tr_on && s_q.esc_pend;        // [R08] [R12]
            s_d.esc_pend = 1'b0;
          end
          else
            s_d.esc_pend = tr_on && is_esc && !s_q.esc_pend; // [R07]
        end
      end
      ST_OPEN:
      begin
        if (rx.valid)
        begin
          if (!s_q.tr)
          begin
            s_d.acc = alg_step(s_q.ctrl.alg, s_q.acc, rx.data);
            if (is_end)
            begin
              s_d.st  = ST_CHECK;                         // [R02] [R04]
              s_d.cnt = 3'h0;
            end
          end
          else if (!s_q.esc_pend)
          begin
            if (is_esc)
              s_d.esc_pend = 1'b1;                        // [R09]
            else
              s_d.acc = alg_step(s_q.ctrl.alg, s_q.acc, rx.data); // [R08]
          end
          else
          begin
            s_d.esc_pend = 1'b0;
            if (is_esc)
              s_d.acc = alg_step(s_q.ctrl.alg, s_q.acc, rx.data); // [R10]
            else if (!is_sync)
            begin
              s_d.acc = alg_step(s_q.ctrl.alg, s_q.acc, rx.data); // [R11]
              if (is_end)
              begin
                s_d.st  = ST_CHECK;                       // [R08]
                s_d.cnt = 3'h0;
              end
            end
          end
        end
      end
      ST_CHECK:
      begin
        if (rx.valid)
        begin
          s_d.win = win_nx;
          s_d.cnt = s_q.cnt + 3'h1;
          if (s_q.cnt + 3'h1 == need)
          begin
            s_d.st   = ST_IDLE;                           // [R03]
            s_d.tr   = 1'b0;
            s_d.calc = expv;
            s_d.recv = gotv;
            ev_pass  = expv == gotv;                      // [R16]
            ev_err   = expv != gotv;
          end
        end
      end
      ST_FRAME:
      begin
        if (rx.frame_end)
        begin
          s_d.st   = ST_IDLE;
          s_d.calc = expv;
          s_d.recv = win_take(s_q.win, need);
          ev_pass  = (s_q.cnt == need) && (expv == win_take(s_q.win, need)); // [R06]
          ev_err   = !ev_pass;                            // [R16]
        end
        else if (rx.valid)
        begin
          s_d.win = win_nx;
          if (s_q.cnt == need)
            s_d.acc = alg_step(s_q.ctrl.alg, s_q.acc, win_old(s_q.win, need)); // [R06]
          else
            s_d.cnt = s_q.cnt + 3'h1;
        end
      end
      default:
        s_d.st = ST_IDLE;
    endcase

    // a frame start restarts the frame when in flag mode, unless a control write in the same cycle returns to idle
    if (s_q.ctrl.mode_flag && rx.frame_start)
    begin
      s_d.st  = ST_FRAME;                                 // [R05]
      s_d.acc = alg_init(s_q.ctrl.alg);                   // [R15] [R17]
      s_d.cnt = 3'h0;
      s_d.win = 32'h0000_0000;
      s_d.tr  = 1'b0;
    end

    s_d.pass = ev_pass;
    s_d.err  = ev_err;

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL:
        begin
          s_d.ctrl.mode_flag                   = reg_wdata[CTRL_MODE_POS];
          s_d.ctrl.alg                         = reg_wdata[CTRL_ALG_POS +: 3];
          s_d.ctrl.longitudinal_parity_odd     = reg_wdata[CTRL_ODD_POS];      // [R13]
          s_d.ctrl.escape_transparency_setting = reg_wdata[CTRL_TRAN_POS];     // [R07]
          s_d.st       = ST_IDLE;
          s_d.esc_pend = 1'b0;
          s_d.tr       = 1'b0;
        end
        REG_BEGIN:
        begin
          s_d.codes.begin0 = reg_wdata[7:0];
          s_d.codes.begin1 = reg_wdata[15:8];
        end
        REG_END:
        begin
          s_d.codes.end0 = reg_wdata[7:0];
          s_d.codes.end1 = reg_wdata[15:8];
        end
        REG_CODES:
        begin
          s_d.codes.itb               = reg_wdata[7:0];
          s_d.codes.escape_char_value = reg_wdata[15:8];
          s_d.codes.sync              = reg_wdata[23:16];
        end
        REG_STATUS:
          clr = reg_wdata[1:0];
        REG_MASK:
          s_d.mask = reg_wdata[1:0];
        default:
          s_d.mask = s_q.mask;
      endcase
    end

    // sticky status, a new event wins over a clear in the same cycle
    s_d.status[ST_PASS_POS] = (s_q.status[ST_PASS_POS] && !clr[ST_PASS_POS]) || ev_pass;
    s_d.status[ST_ERR_POS]  = (s_q.status[ST_ERR_POS] && !clr[ST_ERR_POS]) || ev_err;

    // register reads, data in the following cycle
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:   s_d.rdata = {26'h000_0000, s_q.ctrl.escape_transparency_setting,
                                 s_q.ctrl.longitudinal_parity_odd, s_q.ctrl.alg,
                                 s_q.ctrl.mode_flag};
        REG_BEGIN:  s_d.rdata = {16'h0000, s_q.codes.begin1, s_q.codes.begin0};
        REG_END:    s_d.rdata = {16'h0000, s_q.codes.end1, s_q.codes.end0};
        REG_CODES:  s_d.rdata = {8'h00, s_q.codes.sync, s_q.codes.escape_char_value,
                                 s_q.codes.itb};
        REG_STATUS: s_d.rdata = {30'h0000_0000, s_q.status};
        REG_MASK:   s_d.rdata = {30'h0000_0000, s_q.mask};
        REG_CALC:   s_d.rdata = s_q.calc;
        REG_RECV:   s_d.rdata = s_q.recv;
        default:    s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s_q          <= '0;
      s_q.st       <= ST_IDLE;
      s_q.ctrl     <= ctrl_t'(CTRL_RST[5:0]);
      s_q.codes    <= {BEGIN_RST, END_RST, ITB_RST, ESC_RST, SYNC_RST};
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata   = s_q.rdata;
  assign check_pass  = s_q.pass;
  assign check_error = s_q.err;
  assign irq         = |(s_q.status & s_q.mask);

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence open_char_block;
    s_q.st == ST_IDLE && !s_q.ctrl.mode_flag && rx.valid && is_begin && !reg_wr;
  endsequence

  sequence transparent_open;
    s_q.st == ST_OPEN && s_q.tr && rx.valid && !reg_wr && !rx.frame_start;
  endsequence

  a_begin_opens: assert property (open_char_block |=>    // [R01]
    s_q.st == ST_OPEN && s_q.acc == alg_init(s_q.ctrl.alg))
    else $error("begin code did not open a preset block");

  a_end_closes: assert property (                       // [R02]
    s_q.st == ST_OPEN && !s_q.tr && rx.valid && is_end && !reg_wr && !rx.frame_start
    |=> s_q.st == ST_CHECK && s_q.cnt == 3'h0
        && s_q.acc == alg_step(s_q.ctrl.alg, $past(s_q.acc), $past(rx.data)))
    else $error("end code not accumulated or block not closed");

  a_check_result: assert property (                     // [R03]
    s_q.st == ST_CHECK && rx.valid && s_q.cnt + 3'h1 == need && !reg_wr && !rx.frame_start
    |=> (check_pass ^ check_error) && s_q.st == ST_IDLE)
    else $error("check value not compared after last check char");

  a_lone_end_data: assert property (transparent_open ##0 !s_q.esc_pend && is_end // [R08]
    && !is_esc |=> s_q.st == ST_OPEN)
    else $error("lone end code closed a transparent block");

  a_escape_skipped: assert property (transparent_open ##0 !s_q.esc_pend && is_esc // [R09]
    |=> $stable(s_q.acc) && s_q.esc_pend)
    else $error("escape char entered the accumulation");

  a_double_escape: assert property (transparent_open ##0 s_q.esc_pend && is_esc // [R10]
    |=> !s_q.esc_pend && s_q.acc == alg_step(s_q.ctrl.alg, $past(s_q.acc), $past(rx.data)))
    else $error("second escape not accumulated");

  a_sync_skipped: assert property (transparent_open ##0 s_q.esc_pend && is_sync // [R11]
    && !is_esc |=> $stable(s_q.acc) && s_q.st == ST_OPEN)
    else $error("sync after escape entered the accumulation");

  a_frame_start: assert property (s_q.ctrl.mode_flag && rx.frame_start && !reg_wr // [R05]
    |=> s_q.st == ST_FRAME && s_q.cnt == 3'h0 && s_q.acc == alg_init(s_q.ctrl.alg))
    else $error("frame start did not preset the accumulator");

  a_frame_close: assert property (                      // [R06]
    s_q.st == ST_FRAME && rx.frame_end && !rx.frame_start && !reg_wr
    |=> (check_pass ^ check_error) ##1 !check_pass && !check_error)
    else $error("closing flag gave no single result pulse");

  a_pass_match: assert property (check_pass |-> s_q.calc == s_q.recv && !check_error) // [R16]
    else $error("pass reported on a mismatching check value");

  a_status_sticky: assert property (check_error |-> s_q.status[ST_ERR_POS]) // [R16]
    else $error("error event lost from status");

  a_idle_ignores: assert property (                     // [R17]
    s_q.st == ST_IDLE && !s_q.ctrl.mode_flag && rx.valid && !is_begin && !reg_wr
    |=> s_q.st == ST_IDLE && $stable(s_q.acc))
    else $error("char outside a block changed the state");

  a_itb_closes: assert property (                       // [R04]
    s_q.st == ST_OPEN && !s_q.tr && rx.valid && rx.data == s_q.codes.itb && !reg_wr
    |=> s_q.st == ST_CHECK)
    else $error("intermediate block code did not close the block");

  a_plain_block: assert property (open_char_block ##0 !s_q.esc_pend |=> !s_q.tr) // [R12]
    else $error("unescaped begin opened a transparent block");

  a_escaped_begin: assert property (open_char_block ##0 s_q.esc_pend && tr_on // [R08]
    |=> s_q.tr)
    else $error("escaped begin did not open a transparent block");

  a_flag_waits: assert property (                       // [R05]
    s_q.ctrl.mode_flag && s_q.st == ST_IDLE && !rx.frame_start && !reg_wr
    |=> s_q.st == ST_IDLE)
    else $error("flag mode left idle without a frame start");

  a_fcs_window: assert property (                       // [R06]
    s_q.st == ST_FRAME && rx.valid && s_q.cnt != need && !rx.frame_end && !rx.frame_start
    && !reg_wr |=> s_q.cnt == $past(s_q.cnt) + 3'h1 && $stable(s_q.acc))
    else $error("char accumulated before the fcs window was full");

  a_check_count: assert property (                      // [R03]
    s_q.st == ST_CHECK && rx.valid && s_q.cnt + 3'h1 != need && !reg_wr
    |=> s_q.st == ST_CHECK && !check_pass && !check_error)
    else $error("check ended before all check chars arrived");

  a_one_result: assert property (!(check_pass && check_error)) // [R16]
    else $error("pass and error reported together");

  a_status_clear: assert property (                     // [R16]
    reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_PASS_POS] && !s_d.pass
    |=> !s_q.status[ST_PASS_POS])
    else $error("pass status not cleared by writing one");

  a_ctrl_abort: assert property (reg_wr && reg_addr == REG_CTRL // [R07]
    |=> s_q.st == ST_IDLE && !s_q.tr && !s_q.esc_pend)
    else $error("control write did not abort the block");

  a_read_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data shown without a read");

endmodule // block_check_calculator

/* File: bcc_pkg.sv */
// constants, register map, state record and check arithmetic for the block check calculator
// assumes one clock domain and a line receiver that hands over whole characters
package bcc_pkg;

  // register word index on the plain register port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_BEGIN  = 4'h1;
  localparam logic [3:0] REG_END    = 4'h2;
  localparam logic [3:0] REG_CODES  = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MASK   = 4'h5;
  localparam logic [3:0] REG_CALC   = 4'h6;
  localparam logic [3:0] REG_RECV   = 4'h7;

  // control field positions
  localparam int CTRL_MODE_POS = 0;
  localparam int CTRL_ALG_POS  = 1;
  localparam int CTRL_ODD_POS  = 4;
  localparam int CTRL_TRAN_POS = 5;

  // status and mask bit positions
  localparam int ST_PASS_POS = 0;
  localparam int ST_ERR_POS  = 1;

  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [15:0] BEGIN_RST = 16'h0202;
  localparam logic [15:0] END_RST   = 16'h0303;
  localparam logic [7:0]  ITB_RST   = 8'h1f;
  localparam logic [7:0]  ESC_RST   = 8'h10;
  localparam logic [7:0]  SYNC_RST  = 8'h16;

  // check algorithms
  localparam logic [2:0] ALG_LRC   = 3'h0;
  localparam logic [2:0] ALG_CRC6  = 3'h1;
  localparam logic [2:0] ALG_CRC12 = 3'h2;
  localparam logic [2:0] ALG_CRC16 = 3'h3;
  localparam logic [2:0] ALG_CITT  = 3'h4;
  localparam logic [2:0] ALG_FCS16 = 3'h5;
  localparam logic [2:0] ALG_FCS32 = 3'h6;

  // bit reversed generator polynomials, data taken lsb first
  localparam logic [31:0] POLY_CRC6  = 32'h0000_0021;
  localparam logic [31:0] POLY_CRC12 = 32'h0000_0f01;
  localparam logic [31:0] POLY_CRC16 = 32'h0000_a001;
  localparam logic [31:0] POLY_CITT  = 32'h0000_8408;
  localparam logic [31:0] POLY_FCS32 = 32'hedb8_8320;
  localparam logic [31:0] FCS16_ONES = 32'h0000_ffff;
  localparam logic [31:0] FCS32_ONES = 32'hffff_ffff;
  localparam logic [31:0] LRC_MASK   = 32'h0000_00ff;

  typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_CHECK, ST_FRAME} blk_state_t;

  typedef struct packed {
    logic       mode_flag;
    logic [2:0] alg;
    logic       longitudinal_parity_odd;
    logic       escape_transparency_setting;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] begin0;
    logic [7:0] begin1;
    logic [7:0] end0;
    logic [7:0] end1;
    logic [7:0] itb;
    logic [7:0] escape_char_value;
    logic [7:0] sync;
  } codes_t;

  typedef struct packed {
    blk_state_t  st;
    logic        tr;
    logic        esc_pend;
    logic [2:0]  cnt;
    logic [31:0] acc;
    logic [31:0] win;
    ctrl_t       ctrl;
    codes_t      codes;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [31:0] calc;
    logic [31:0] recv;
    logic [31:0] rdata;
    logic        pass;
    logic        err;
  } state_t;

  // received character from the line receiver
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       frame_start;
    logic       frame_end;
  } rx_t;

  function automatic logic [31:0] alg_init(input logic [2:0] alg);
    case (alg)
      ALG_FCS16: alg_init = FCS16_ONES;
      ALG_FCS32: alg_init = FCS32_ONES;
      default:   alg_init = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [2:0] alg_len(input logic [2:0] alg);
    case (alg)
      ALG_LRC, ALG_CRC6: alg_len = 3'h1;
      ALG_FCS32:         alg_len = 3'h4;
      default:           alg_len = 3'h2;
    endcase
  endfunction

  function automatic logic [31:0] alg_step(input logic [2:0] alg, input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    logic [31:0] p;
    logic        fb;
    r = c;
    case (alg)
      ALG_CRC6:  p = POLY_CRC6;                          // [R14]
      ALG_CRC12: p = POLY_CRC12;
      ALG_CRC16: p = POLY_CRC16;
      ALG_FCS32: p = POLY_FCS32;
      default:   p = POLY_CITT;
    endcase
    if (alg == ALG_LRC)
      r = c ^ {24'h00_0000, d};
    else
      for (int i = 0; i < 8; i++)
      begin
        fb = r[0] ^ d[i];
        r  = r >> 1;
        if (fb)
          r = r ^ p;
      end
    alg_step = r;
  endfunction

  function automatic logic [31:0] alg_expect(input logic [2:0] alg, input logic odd,
                                             input logic [31:0] c);
    case (alg)
      ALG_LRC:   alg_expect = odd ? (~c & LRC_MASK) : (c & LRC_MASK);
      ALG_FCS16: alg_expect = ~c & FCS16_ONES;
      ALG_FCS32: alg_expect = ~c;
      default:   alg_expect = c;
    endcase
  endfunction

  // newest n characters of the window, first received in the low byte
  function automatic logic [31:0] win_take(input logic [31:0] w, input logic [2:0] n);
    case (n)
      3'h1:    win_take = {24'h00_0000, w[31:24]};
      3'h2:    win_take = {16'h0000, w[31:16]};
      3'h3:    win_take = {8'h00, w[31:8]};
      default: win_take = w;
    endcase
  endfunction

  // character about to leave the n newest of the window
  function automatic logic [7:0] win_old(input logic [31:0] w, input logic [2:0] n);
    case (n)
      3'h1:    win_old = w[31:24];
      3'h2:    win_old = w[23:16];
      3'h3:    win_old = w[15:8];
      default: win_old = w[7:0];
    endcase
  endfunction

endpackage

/* File: line_rx_model.sv */
// line receiver model: hands decoded characters and frame markers to the calculator
// assumes the bench calls its tasks just after a rising edge of mclk
`timescale 1ns/1ps

module line_rx_model
  import bcc_pkg::*;
(
  // clock
  input  wire logic    mclk,
  // decoded characters towards the calculator
  output bcc_pkg::rx_t rx
);
  initial rx = '{1'b0, 8'ha5, 1'b0, 1'b0};

  // one character, strobe held for one cycle
  task automatic put_char(input logic [7:0] d);
    rx <= '{1'b1, d, 1'b0, 1'b0};
    @(posedge mclk);
  endtask

  // opening flag when start is high, closing flag otherwise; never beside a character
  task automatic put_mark(input logic start);
    rx <= '{1'b0, ~rx.data, start, ~start};
    @(posedge mclk);
  endtask

  // idle line: data no longer shows the last character
  task automatic release_line();
    rx <= '{1'b0, ~rx.data, 1'b0, 1'b0};
  endtask

  // slow sender: one idle cycle
  task automatic gap();
    release_line();
    @(posedge mclk);
  endtask
endmodule // line_rx_model

/* File: block_check_calculator_test.sv */
// self-checking bench for the block check calculator
// assumes line_rx_model as the character source and a 20 MHz mclk
`timescale 1ns/1ps

module block_check_calculator_test;
  import bcc_pkg::*;

  logic        mclk;
  logic        rst_n;
  rx_t         rx;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        check_pass;
  logic        check_error;
  logic        irq;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [2:0]  cur_alg;
  logic        cur_odd;
  logic        irq_on;
  logic [31:0] acc;

  block_check_calculator block_check_calculator_inst (
    .mclk(mclk), .rst_n(rst_n), .rx(rx), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .check_pass(check_pass),
    .check_error(check_error), .irq(irq));

  line_rx_model line_rx_model_inst (.mclk(mclk), .rx(rx));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      finish_test();
    end
  end

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic reg_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(what, reg_rdata, exp);
    @(posedge mclk);
  endtask

  function automatic logic [31:0] step(input logic [2:0] a, input logic [31:0] c,
                                       input logic [7:0] d);
    logic [31:0] p;
    p = a == ALG_CRC6 ? POLY_CRC6 : a == ALG_CRC12 ? POLY_CRC12 :
        a == ALG_CRC16 ? POLY_CRC16 : a == ALG_FCS32 ? POLY_FCS32 : POLY_CITT;
    if (a == ALG_LRC)
      return c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++)
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? p : 32'h0000_0000);
    return c;
  endfunction

  function automatic logic [31:0] chkval();
    case (cur_alg)
      ALG_LRC:   return {24'h00_0000, cur_odd ? ~acc[7:0] : acc[7:0]};
      ALG_FCS16: return {16'h0000, ~acc[15:0]};
      ALG_FCS32: return ~acc;
      default:   return acc;
    endcase
  endfunction

  task automatic set_mode(input logic m, input logic [2:0] a, input logic o, input logic t);
    cur_alg = a;
    cur_odd = o;
    reg_write(REG_CTRL, {26'h000_0000, t, o, a, m});
  endtask

  // block opens: accumulator preset for the selected check
  task automatic open_blk();
    acc = cur_alg == ALG_FCS16 ? 32'h0000_ffff : cur_alg == ALG_FCS32 ? 32'hffff_ffff : 32'h0;
  endtask

  task automatic raw(input logic [7:0] d);
    line_rx_model_inst.put_char(d);
  endtask

  task automatic sd(input logic [7:0] d);
    line_rx_model_inst.put_char(d);
    acc = step(cur_alg, acc, d);
  endtask

  // check characters, first one in the low byte
  task automatic send_bcc(input logic [31:0] flip);
    logic [31:0] v;
    int          n;
    v = chkval() ^ flip;
    n = (cur_alg == ALG_LRC || cur_alg == ALG_CRC6) ? 1 : cur_alg == ALG_FCS32 ? 4 : 2;
    for (int i = 0; i < n; i++)
      raw(v[8*i +: 8]);
  endtask

  task automatic expect_done(input string what, input logic pass);
    line_rx_model_inst.release_line();
    @(negedge mclk);
    chk({what, " pass"}, {31'h0, check_pass}, {31'h0, pass});
    chk({what, " error"}, {31'h0, check_error}, {31'h0, ~pass});
    @(posedge mclk);
    reg_chk({what, " calc"}, REG_CALC, chkval());
    reg_chk({what, " recv"}, REG_RECV, chkval() ^ {31'h0, ~pass});
    reg_chk({what, " status"}, REG_STATUS, {30'h0, ~pass, pass});
    chk({what, " irq"}, {31'h0, irq}, {31'h0, irq_on});
    reg_write(REG_STATUS, 32'h0000_0003);
    chk({what, " irq clear"}, {31'h0, irq}, 32'h0);
    $display("test %s done", what);
  endtask

  task automatic t_regs();
    reg_chk("ctrl", REG_CTRL, 32'h0000_0000);
    reg_chk("begin", REG_BEGIN, 32'h0000_0202);
    reg_chk("end", REG_END, 32'h0000_0303);
    reg_chk("codes", REG_CODES, 32'h0016_101f);
    reg_chk("status", REG_STATUS, 32'h0000_0000);
    reg_chk("mask", REG_MASK, 32'h0000_0000);
    reg_write(4'h8, 32'hffff_ffff);
    reg_chk("unmapped", 4'h8, 32'h0000_0000);
    reg_write(REG_BEGIN, 32'h0000_0102);
    reg_chk("begin wr", REG_BEGIN, 32'h0000_0102);
    $display("test regs done");
  endtask

  task automatic t_lrc();
    irq_on = 1'b0;
    set_mode(1'b0, ALG_LRC, 1'b0, 1'b0);
    raw(8'h41);
    raw(8'h02);
    open_blk();
    sd(8'h11);
    sd(8'h5a);
    sd(8'h03);
    send_bcc(32'h0);
    expect_done("lrc even", 1'b1);
    reg_write(REG_MASK, 32'h0000_0003);
    irq_on = 1'b1;
    set_mode(1'b0, ALG_LRC, 1'b1, 1'b0);
    raw(8'h01);
    open_blk();
    sd(8'ha5);
    sd(8'h03);
    send_bcc(32'h0000_0001);
    expect_done("lrc odd bad", 1'b0);
  endtask

  task automatic t_crc();
    for (int a = 1; a < 5; a++)
    begin
      set_mode(1'b0, 3'(a), 1'b0, 1'b0);
      raw(8'h02);
      open_blk();
      sd(8'h31);
      sd(8'h32);
      sd(a == 4 ? ITB_RST : 8'h03);
      send_bcc(32'h0);
      expect_done("crc", 1'b1);
    end
  endtask

  task automatic t_flag();
    set_mode(1'b1, ALG_FCS16, 1'b0, 1'b0);
    raw(8'h99);
    line_rx_model_inst.put_mark(1'b1);
    open_blk();
    sd(8'hc3);
    line_rx_model_inst.gap();
    sd(8'h81);
    send_bcc(32'h0);
    line_rx_model_inst.put_mark(1'b0);
    expect_done("fcs16", 1'b1);
    set_mode(1'b1, ALG_FCS32, 1'b0, 1'b0);
    line_rx_model_inst.put_mark(1'b1);
    open_blk();
    sd(8'h01);
    sd(8'h02);
    sd(8'h03);
    send_bcc(32'h0);
    line_rx_model_inst.put_mark(1'b0);
    expect_done("fcs32", 1'b1);
  endtask

  task automatic t_trans();
    set_mode(1'b0, ALG_LRC, 1'b0, 1'b1);
    raw(ESC_RST);
    raw(8'h02);
    open_blk();
    sd(8'h41);
    sd(8'h03);
    raw(ESC_RST);
    sd(ESC_RST);
    raw(ESC_RST);
    raw(SYNC_RST);
    raw(ESC_RST);
    sd(8'h03);
    send_bcc(32'h0);
    expect_done("transparent", 1'b1);
    raw(8'h02);
    open_blk();
    sd(ESC_RST);
    sd(8'h03);
    send_bcc(32'h0);
    expect_done("plain block", 1'b1);
    reg_write(REG_CODES, 32'h0016_1b1f);
    raw(8'h1b);
    raw(8'h02);
    open_blk();
    sd(ESC_RST);
    raw(8'h1b);
    sd(8'h03);
    send_bcc(32'h0);
    expect_done("new escape", 1'b1);
  endtask

  initial
  begin
    rst_n     = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    irq_on    = 1'b0;
    cur_alg   = ALG_LRC;
    cur_odd   = 1'b0;
    acc       = 32'h0000_0000;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_lrc();
    t_crc();
    t_flag();
    t_trans();
    finish_test();
  end
endmodule // block_check_calculator_test
